// [inc/gpp67_pkg.sv]
/*
  gpp67_pkg: register offsets, widths, reset values and pin positions
  for the two general-purpose ports. assumes a plain byte register port.
*/
package gpp67_pkg;
  localparam int GPP_AW = 4;
  localparam int GPP_DW = 8;
  localparam logic [GPP_AW-1:0] OFS_P6_DATA = 4'h0;
  localparam logic [GPP_AW-1:0] OFS_P6_DIR = 4'h1;
  localparam logic [GPP_AW-1:0] OFS_P6_PULL = 4'h2;
  localparam logic [GPP_AW-1:0] OFS_P7_DATA = 4'h4;
  localparam logic [GPP_AW-1:0] OFS_P7_DIR = 4'h5;
  localparam logic [GPP_AW-1:0] OFS_P7_PULL = 4'h6;
  localparam logic [GPP_AW-1:0] OFS_STBY = 4'h8;
  localparam logic [GPP_AW-1:0] OFS_WAKE = 4'h9;
  localparam logic [GPP_DW-1:0] RST_DIR = 8'h00;
  localparam logic [GPP_DW-1:0] RST_DATA = 8'h00;
  localparam logic [GPP_DW-1:0] RST_PULL = 8'h00;
  localparam logic [GPP_DW-1:0] P7_MASK = 8'h07;
  localparam logic [GPP_DW-1:0] ZERO8 = 8'h00;
  localparam int STBY_FLOAT_BIT = 0;
  localparam int STBY_STOP_BIT = 1;
  localparam int WAKE_SCK_BIT = 0;
  localparam int WAKE_SIN_BIT = 1;
  localparam int P6_SCK_PIN = 5;
  localparam int P6_SIN_PIN = 7;
  localparam int P6_PG_A = 0;
  localparam int P6_PG_B = 1;
  localparam int P6_TM_A = 2;
  localparam int P6_TM_B = 3;
  localparam int P6_TCLK = 4;
  localparam int P6_SOUT = 6;
  localparam int P7_RT_OUT = 0;
  localparam int P7_RT_IN = 1;
endpackage

// [verilog/gpp67_pin.sv]
/*
  gpp67_pin: one pad's output, enable, pull-up and input gating.
  assumes the pad resolves the wire from oe_n and reflects it on padIn.
*/
`timescale 1ns/10ps
`default_nettype none
module gpp67_pin (
  input wire logic latchBit,
  input wire logic dirBit,
  input wire logic perEn,
  input wire logic perOut,
  input wire logic pullEn,
  input wire logic floatNow,
  input wire logic keepIn,
  input wire logic padIn,
  output logic padOut,
  output logic padOeN,
  output logic pullOn,
  output logic inGated
);
  logic drive;
  always_comb begin
    drive = (perEn | dirBit) & ~floatNow; // [R1] [R2] [R10] [R12]
    padOut = perEn ? perOut : latchBit; // [R6] [R1]
    padOeN = ~drive;
    // pull-up off while driving low, and off while floating
    pullOn = pullEn & ~(drive & ~padOut) & ~floatNow; // [R13] [R14]
    inGated = (floatNow & ~keepIn) ? 1'b0 : padIn; // [R10] [R11]
  end
endmodule
`default_nettype wire

// [verilog/gpp67_port.sv]
/*
  gpp67_port: pin slice array of one port, width by parameter.
  assumes peripheral enables come from the owning peripherals.
*/
`timescale 1ns/10ps
`default_nettype none
module gpp67_port #(
  parameter int W = 8
) (
  input wire logic [W-1:0] latchV,
  input wire logic [W-1:0] dirV,
  input wire logic [W-1:0] perEnV,
  input wire logic [W-1:0] perOutV,
  input wire logic [W-1:0] pullV,
  input wire logic floatNow,
  input wire logic [W-1:0] keepInV,
  input wire logic [W-1:0] padInV,
  output logic [W-1:0] padOutV,
  output logic [W-1:0] padOeNV,
  output logic [W-1:0] pullOnV,
  output logic [W-1:0] inGatedV
);
  initial begin
    if (W < 1 || W > 8) $error("port width must be 1..8");
  end
  for (genvar i = 0; i < W; i++) begin : g_pin
    gpp67_pin uPin (
      .latchBit(latchV[i]),
      .dirBit(dirV[i]),
      .perEn(perEnV[i]),
      .perOut(perOutV[i]),
      .pullEn(pullV[i]),
      .floatNow(floatNow),
      .keepIn(keepInV[i]),
      .padIn(padInV[i]),
      .padOut(padOutV[i]),
      .padOeN(padOeNV[i]),
      .pullOn(pullOnV[i]),
      .inGated(inGatedV[i])
    );
  end
endmodule
`default_nettype wire

// [verilog/gpp67_top.sv]
/*
  gpp67_top: register file and pin muxing for the eight-pin and the
  three-pin general-purpose ports. assumes a byte register port with
  read data one cycle after the read strobe, and pads outside.
*/
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
// What this block and its software do
// R1: direction bit 1 makes the pin an output driven from the latch.
// R2: direction bit 0 makes the pin an input, latch not driven.
// R3: data writes always update the latch; only outputs show it.
// R4: reading an output pin's data bit returns the latch.
// R5: input or peripheral pins read pin level; rmw read returns latch.
// R6: peripheral output enable routes peripheral output to the pin.
// R7: with a peripheral driving, a normal read returns the pin level.
// R8: software clears direction for peripheral inputs; reads give pins.
// R9: reset clears all direction bits so every pin is an input.
// R10: float bit in stop or watch: pins hi-z, inputs forced low.
// R11: serial clock and data-in inputs stay open when wake enabled.
// R12: float bit 0 in standby leaves pins and levels unchanged.
// R13: pull-up enable bit 1 connects the internal pull-up.
// R14: a pin driving low always has its pull-up disconnected.
// R15: eight-pin port bits 0..7 map pins; three-pin port bits 0..2.
// R16: eight-pin port carries pulse, timer, clock-in and serial pins.
// R17: three-pin port carries reload timer out, in and plain pin.
// R18: software disables shared peripheral output before port use.
// R19: unused three-pin port bits ignore writes and read zero.
`timescale 1ns/10ps
`default_nettype none
module gpp67_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic [gpp67_pkg::GPP_AW-1:0] regAddr,
  input wire logic [gpp67_pkg::GPP_DW-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic regRmw,
  output logic [gpp67_pkg::GPP_DW-1:0] regRdata,
  input wire logic standbyEnter,
  input wire logic pulseGen1OutA,
  input wire logic pulseGen1OutB,
  input wire logic pulseGen1EnA,
  input wire logic pulseGen1EnB,
  input wire logic compTimer1OutA,
  input wire logic compTimer1OutB,
  input wire logic compTimer1EnA,
  input wire logic compTimer1EnB,
  input wire logic serialClockOut,
  input wire logic serialClockEn,
  input wire logic serialDataOut,
  input wire logic serialDataOutEn,
  input wire logic reloadTimer0Out,
  input wire logic reloadTimer0OutEn,
  output logic compTimer1ClockIn,
  output logic serialClockIn,
  output logic serialDataIn,
  output logic reloadTimer0In,
  input wire logic [7:0] port6PadIn,
  output logic [7:0] port6PadOut,
  output logic [7:0] port6PadOeN,
  output logic [7:0] port6PullOn,
  input wire logic [2:0] port7PadIn,
  output logic [2:0] port7PadOut,
  output logic [2:0] port7PadOeN,
  output logic [2:0] port7PullOn
);
  import gpp67_pkg::*;

  typedef struct packed {
    logic [GPP_DW-1:0] p6Data;
    logic [GPP_DW-1:0] p6Dir;
    logic [GPP_DW-1:0] p6Pull;
    logic [GPP_DW-1:0] p7Data;
    logic [GPP_DW-1:0] p7Dir;
    logic [GPP_DW-1:0] p7Pull;
    logic floatSel;
    logic inStandby;
    logic wakeSck;
    logic wakeSin;
    logic [GPP_DW-1:0] rdata;
    logic [7:0] p6Out;
    logic [7:0] p6OeN;
    logic [7:0] p6PullOn;
    logic [2:0] p7Out;
    logic [2:0] p7OeN;
    logic [2:0] p7PullOn;
    logic tclkIn;
    logic sckIn;
    logic sinIn;
    logic rtIn;
  } gpp_state_t;

  localparam gpp_state_t RST_STATE = '{
    p6Data: RST_DATA, p6Dir: RST_DIR, p6Pull: RST_PULL,
    p7Data: RST_DATA, p7Dir: RST_DIR, p7Pull: RST_PULL,
    floatSel: 1'b0, inStandby: 1'b0, wakeSck: 1'b0, wakeSin: 1'b0,
    rdata: ZERO8, p6Out: 8'h00, p6OeN: 8'hff, p6PullOn: 8'h00,
    p7Out: 3'h0, p7OeN: 3'h7, p7PullOn: 3'h0,
    tclkIn: 1'b0, sckIn: 1'b0, sinIn: 1'b0, rtIn: 1'b0
  };

  gpp_state_t st_r;
  gpp_state_t st_nxt;

  // read view of a port's data register: latch on outputs not driven by a peripheral, and on rmw
  function automatic logic [GPP_DW-1:0] dataView(
    input logic [GPP_DW-1:0] latchV,
    input logic [GPP_DW-1:0] dirV,
    input logic [GPP_DW-1:0] perEnV,
    input logic [GPP_DW-1:0] pinV,
    input logic rmw
  );
    logic [GPP_DW-1:0] gpOut;
    gpOut = dirV & ~perEnV;
    if (rmw) begin
      dataView = latchV; // [R5]
    end else begin
      dataView = (gpOut & latchV) | (~gpOut & pinV); // [R4] [R5] [R7] [R8]
    end
  endfunction

  logic floatNow;
  logic [7:0] p6PerEn;
  logic [7:0] p6PerOut;
  logic [7:0] p6Keep;
  logic [2:0] p7PerEn;
  logic [2:0] p7PerOut;
  logic [2:0] p7Keep;
  logic [7:0] p6PadOutC;
  logic [7:0] p6OeNC;
  logic [7:0] p6PullC;
  logic [7:0] p6InC;
  logic [2:0] p7PadOutC;
  logic [2:0] p7OeNC;
  logic [2:0] p7PullC;
  logic [2:0] p7InC;

  assign floatNow = st_r.floatSel & st_r.inStandby; // [R10] [R12]

  always_comb begin
    p6PerEn = 8'h00;
    p6PerOut = 8'h00;
    p6Keep = 8'h00;
    p7PerEn = 3'h0;
    p7PerOut = 3'h0;
    p7Keep = 3'h0;
    p6PerEn[P6_PG_A] = pulseGen1EnA; // [R16]
    p6PerOut[P6_PG_A] = pulseGen1OutA;
    p6PerEn[P6_PG_B] = pulseGen1EnB;
    p6PerOut[P6_PG_B] = pulseGen1OutB;
    p6PerEn[P6_TM_A] = compTimer1EnA;
    p6PerOut[P6_TM_A] = compTimer1OutA;
    p6PerEn[P6_TM_B] = compTimer1EnB;
    p6PerOut[P6_TM_B] = compTimer1OutB;
    p6PerEn[P6_SCK_PIN] = serialClockEn;
    p6PerOut[P6_SCK_PIN] = serialClockOut;
    p6PerEn[P6_SOUT] = serialDataOutEn;
    p6PerOut[P6_SOUT] = serialDataOut;
    p6Keep[P6_SCK_PIN] = st_r.wakeSck; // [R11]
    p6Keep[P6_SIN_PIN] = st_r.wakeSin; // [R11]
    p7PerEn[P7_RT_OUT] = reloadTimer0OutEn; // [R17]
    p7PerOut[P7_RT_OUT] = reloadTimer0Out;
  end

  gpp67_port #(.W(8)) uPort6 (
    .latchV(st_r.p6Data),
    .dirV(st_r.p6Dir),
    .perEnV(p6PerEn),
    .perOutV(p6PerOut),
    .pullV(st_r.p6Pull),
    .floatNow(floatNow),
    .keepInV(p6Keep),
    .padInV(port6PadIn),
    .padOutV(p6PadOutC),
    .padOeNV(p6OeNC),
    .pullOnV(p6PullC),
    .inGatedV(p6InC)
  );

  gpp67_port #(.W(3)) uPort7 (
    .latchV(st_r.p7Data[2:0]),
    .dirV(st_r.p7Dir[2:0]),
    .perEnV(p7PerEn),
    .perOutV(p7PerOut),
    .pullV(st_r.p7Pull[2:0]),
    .floatNow(floatNow),
    .keepInV(p7Keep),
    .padInV(port7PadIn),
    .padOutV(p7PadOutC),
    .padOeNV(p7OeNC),
    .pullOnV(p7PullC),
    .inGatedV(p7InC)
  );

  always_comb begin
    st_nxt = st_r;
    // pad-facing outputs registered, one cycle behind their causes
    st_nxt.p6Out = p6PadOutC;
    st_nxt.p6OeN = p6OeNC;
    st_nxt.p6PullOn = p6PullC;
    st_nxt.p7Out = p7PadOutC;
    st_nxt.p7OeN = p7OeNC;
    st_nxt.p7PullOn = p7PullC;
    st_nxt.tclkIn = p6InC[P6_TCLK]; // [R16]
    st_nxt.sckIn = p6InC[P6_SCK_PIN];
    st_nxt.sinIn = p6InC[P6_SIN_PIN];
    st_nxt.rtIn = p7InC[P7_RT_IN]; // [R17]
    st_nxt.inStandby = standbyEnter;
    st_nxt.rdata = ZERO8;
    if (regWr) begin
      case (regAddr)
        OFS_P6_DATA: st_nxt.p6Data = regWdata; // [R3] [R15]
        OFS_P6_DIR: st_nxt.p6Dir = regWdata;
        OFS_P6_PULL: st_nxt.p6Pull = regWdata; // [R13]
        OFS_P7_DATA: st_nxt.p7Data = regWdata & P7_MASK; // [R3] [R19]
        OFS_P7_DIR: st_nxt.p7Dir = regWdata & P7_MASK; // [R19]
        OFS_P7_PULL: st_nxt.p7Pull = regWdata & P7_MASK; // [R19]
        OFS_STBY: st_nxt.floatSel = regWdata[STBY_FLOAT_BIT];
        OFS_WAKE: begin
          st_nxt.wakeSck = regWdata[WAKE_SCK_BIT];
          st_nxt.wakeSin = regWdata[WAKE_SIN_BIT];
        end
        default: st_nxt.rdata = ZERO8;
      endcase
    end
    if (regRd) begin
      case (regAddr)
        OFS_P6_DATA: st_nxt.rdata = dataView(st_r.p6Data, st_r.p6Dir,
            p6PerEn, p6InC, regRmw);
        OFS_P6_DIR: st_nxt.rdata = st_r.p6Dir;
        OFS_P6_PULL: st_nxt.rdata = st_r.p6Pull;
        OFS_P7_DATA: st_nxt.rdata = dataView(st_r.p7Data, st_r.p7Dir,
            {5'h00, p7PerEn}, {5'h00, p7InC}, regRmw) & P7_MASK; // [R19]
        OFS_P7_DIR: st_nxt.rdata = st_r.p7Dir;
        OFS_P7_PULL: st_nxt.rdata = st_r.p7Pull;
        OFS_STBY: begin
          st_nxt.rdata[STBY_FLOAT_BIT] = st_r.floatSel;
          st_nxt.rdata[STBY_STOP_BIT] = st_r.inStandby;
        end
        OFS_WAKE: begin
          st_nxt.rdata[WAKE_SCK_BIT] = st_r.wakeSck;
          st_nxt.rdata[WAKE_SIN_BIT] = st_r.wakeSin;
        end
        default: st_nxt.rdata = ZERO8;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= RST_STATE; // [R9]
    end else begin
      st_r <= st_nxt;
    end
  end

  assign regRdata = st_r.rdata;
  assign port6PadOut = st_r.p6Out;
  assign port6PadOeN = st_r.p6OeN;
  assign port6PullOn = st_r.p6PullOn;
  assign port7PadOut = st_r.p7Out;
  assign port7PadOeN = st_r.p7OeN;
  assign port7PullOn = st_r.p7PullOn;
  assign compTimer1ClockIn = st_r.tclkIn;
  assign serialClockIn = st_r.sckIn;
  assign serialDataIn = st_r.sinIn;
  assign reloadTimer0In = st_r.rtIn;
endmodule
`default_nettype wire

// [verif/gpp67_board.sv]
/*
  gpp67_board: board wiring at the pads of one port.
  assumes oeN low means the port drives its pad.
*/
`timescale 1ns/10ps
`default_nettype none
module gpp67_board #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic [W-1:0] drv,
  input wire logic [W-1:0] oeN,
  input wire logic [W-1:0] pull,
  input wire logic [W-1:0] extEn,
  input wire logic [W-1:0] extVal,
  output logic [W-1:0] pad
);
  logic [W-1:0] last_r = '0;
  // a quiet wire with its pull-up off flips each cycle, so no read can pass by luck
  assign pad = (~oeN & drv) | (oeN & extEn & extVal)
    | (oeN & ~extEn & (pull | ~last_r));
  always_ff @(posedge clk) begin
    last_r <= pad;
  end
endmodule
`default_nettype wire

// [verif/gpp67_top_chk.sv]
/*
  gpp67_top_chk: port checks of the two general-purpose ports.
  assumes it is bound to gpp67_top and sees only its ports.
*/
`timescale 1ns/10ps
`default_nettype none
module gpp67_top_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic [gpp67_pkg::GPP_AW-1:0] regAddr,
  input wire logic [gpp67_pkg::GPP_DW-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic regRmw,
  input wire logic [gpp67_pkg::GPP_DW-1:0] regRdata,
  input wire logic standbyEnter,
  input wire logic pulseGen1EnA,
  input wire logic pulseGen1EnB,
  input wire logic compTimer1EnA,
  input wire logic compTimer1EnB,
  input wire logic serialClockEn,
  input wire logic serialDataOutEn,
  input wire logic pulseGen1OutA,
  input wire logic compTimer1ClockIn,
  input wire logic serialClockIn,
  input wire logic [7:0] port6PadIn,
  input wire logic [7:0] port6PadOut,
  input wire logic [7:0] port6PadOeN,
  input wire logic [7:0] port6PullOn,
  input wire logic [2:0] port7PadOeN
);
  import gpp67_pkg::*;
  logic [7:0] dir_r, lat_r, pul_r;
  logic [1:0] wak_r;
  logic fl_r;
  // shadows of the port 6, wake and float writable bits, so checks need no hierarchy
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dir_r <= 8'h00;
      lat_r <= 8'h00;
      pul_r <= 8'h00;
      wak_r <= 2'h0;
      fl_r <= 1'b0;
    end else if (regWr) begin
      case (regAddr)
        OFS_P6_DATA: lat_r <= regWdata;
        OFS_P6_DIR: dir_r <= regWdata;
        OFS_P6_PULL: pul_r <= regWdata;
        OFS_WAKE: wak_r <= regWdata[1:0];
        OFS_STBY: fl_r <= regWdata[0];
        default: ;
      endcase
    end
  end
  wire logic floatNow = fl_r & standbyEnter;
  wire logic [7:0] pe = {1'b0, serialDataOutEn, serialClockEn, 1'b0,
    compTimer1EnB, compTimer1EnA, pulseGen1EnB, pulseGen1EnA};
  wire logic [7:0] useLat = dir_r & ~pe;
  wire logic [7:0] rdExp = (useLat & lat_r) | (~useLat & port6PadIn);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_reset_inputs: assert property ($past(rst) |->
    port6PadOeN == 8'hff && port7PadOeN == 3'h7) else $error("pin driven after reset");
  a_dir_drive: assert property (
    (pe == 8'h00 && !floatNow && $stable({dir_r, lat_r}))[*3] |->
    port6PadOeN == ~dir_r && (port6PadOut & dir_r) == (lat_r & dir_r))
    else $error("pin drive differs from direction and latch");
  a_per_route: assert property ((pulseGen1EnA && !floatNow)[*3] |->
    !port6PadOeN[0] && port6PadOut[0] == $past(pulseGen1OutA))
    else $error("peripheral output not on its pin");
  a_pull_low: assert property (
    (port6PullOn & ~port6PadOeN & ~port6PadOut) == 8'h00)
    else $error("pull-up on a pin driving low");
  a_pull_enable: assert property (
    (!floatNow && $stable(pul_r))[*3] |->
    port6PullOn == (pul_r & (port6PadOeN | port6PadOut)))
    else $error("pull-up differs from its enable");
  a_float_pins: assert property (floatNow[*3] |->
    port6PadOeN == 8'hff && port7PadOeN == 3'h7 &&
    port6PullOn == 8'h00 && !compTimer1ClockIn)
    else $error("pin not floated in standby");
  a_float_wake: assert property ((floatNow && $stable(wak_r))[*3] |->
    serialClockIn == ($past(port6PadIn[5]) & wak_r[0]))
    else $error("serial clock input gating wrong");
  a_data_read: assert property (
    regRd && !regRmw && regAddr == OFS_P6_DATA && !fl_r |=>
    regRdata == $past(rdExp)) else $error("data read wrong");
  a_rmw_read: assert property (
    regRd && regRmw && regAddr == OFS_P6_DATA |=> regRdata == $past(lat_r))
    else $error("rmw read not the latch");
  a_narrow_read: assert property (
    regRd && regAddr[3:2] == 2'h1 |=> regRdata[7:3] == 5'h00)
    else $error("unused port bits read nonzero");
  c_rmw: cover property (regRd && regRmw);
  c_float: cover property (floatNow[*3]);
  c_per: cover property (pulseGen1EnA[*3]);
endmodule
bind gpp67_top gpp67_top_chk gpp67_top_chk_inst (.clk, .rst, .regAddr,
  .regWdata, .regWr, .regRd, .regRmw, .regRdata, .standbyEnter,
  .pulseGen1EnA, .pulseGen1EnB, .compTimer1EnA, .compTimer1EnB,
  .serialClockEn, .serialDataOutEn, .pulseGen1OutA, .compTimer1ClockIn,
  .serialClockIn, .port6PadIn, .port6PadOut, .port6PadOeN, .port6PullOn,
  .port7PadOeN);
`default_nettype wire

// [verif/gpp67_top_test.sv]
/*
  gpp67_top_test: register-call tests of the two general-purpose ports.
  assumes the board model and checker files are compiled before it.
*/
`timescale 1ns/10ps
`default_nettype none
module gpp67_top_test;
  import gpp67_pkg::*;
  logic clk, rst, regWr, regRd, regRmw, standbyEnter;
  logic [3:0] regAddr;
  logic [7:0] regWdata, regRdata, ext6En, port6PadIn, port6PadOut;
  logic [7:0] port6PadOeN, port6PullOn;
  logic [2:0] port7PadIn, port7PadOut, port7PadOeN, port7PullOn;
  logic [6:0] pen, pout;
  logic compTimer1ClockIn, serialClockIn, serialDataIn, reloadTimer0In;
  wire logic pulseGen1OutA, pulseGen1OutB, compTimer1OutA, compTimer1OutB;
  wire logic serialClockOut, serialDataOut, reloadTimer0Out;
  wire logic pulseGen1EnA, pulseGen1EnB, compTimer1EnA, compTimer1EnB;
  wire logic serialClockEn, serialDataOutEn, reloadTimer0OutEn;
  int nErrors, totalChecks;
  assign {reloadTimer0Out, serialDataOut, serialClockOut, compTimer1OutB,
    compTimer1OutA, pulseGen1OutB, pulseGen1OutA} = pout;
  assign {reloadTimer0OutEn, serialDataOutEn, serialClockEn, compTimer1EnB,
    compTimer1EnA, pulseGen1EnB, pulseGen1EnA} = pen;
  gpp67_top gpp67_top_inst (.clk, .rst, .regAddr, .regWdata, .regWr, .regRd,
    .regRmw, .regRdata, .standbyEnter, .pulseGen1OutA, .pulseGen1OutB,
    .pulseGen1EnA, .pulseGen1EnB, .compTimer1OutA, .compTimer1OutB,
    .compTimer1EnA, .compTimer1EnB, .serialClockOut, .serialClockEn,
    .serialDataOut, .serialDataOutEn, .reloadTimer0Out, .reloadTimer0OutEn,
    .compTimer1ClockIn, .serialClockIn, .serialDataIn, .reloadTimer0In,
    .port6PadIn, .port6PadOut, .port6PadOeN, .port6PullOn, .port7PadIn,
    .port7PadOut, .port7PadOeN, .port7PullOn);
  gpp67_board #(.W(8)) gpp67_board_inst (.clk, .drv(port6PadOut),
    .oeN(port6PadOeN), .pull(port6PullOn), .extEn(ext6En),
    .extVal(8'hbc), .pad(port6PadIn));
  gpp67_board #(.W(3)) gpp67_board_p7_inst (.clk, .drv(port7PadOut),
    .oeN(port7PadOeN), .pull(port7PullOn), .extEn(3'h0),
    .extVal(3'h0), .pad(port7PadIn));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
    input string nm);
    totalChecks++;
    if (got !== exp) begin
      nErrors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic m,
    input logic [7:0] exp, input string nm);
    @(posedge clk);
    regAddr <= a;
    regRmw <= m;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    regRmw <= 1'b0;
    #1 chk(regRdata, exp, nm);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic closeOut;
    $display("checks %0d errors %0d", totalChecks, nErrors);
    if (nErrors == 0 && totalChecks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // generous: the sequence needs well under a thousand cycles
  initial begin
    #150000;
    nErrors++;
    closeOut();
  end
  initial begin
    {rst, regWr, regRd, regRmw, standbyEnter} = 5'h10;
    {regAddr, regWdata, ext6En} = 20'h00000;
    {pen, pout} = 14'h0000;
    repeat (12) @(posedge clk);
    #1 chk(port6PadOeN, 8'hff, "oe6 reset");
    @(posedge clk);
    rst <= 1'b0;
    rd(OFS_P6_DIR, 1'b0, 8'h00, "dir6");
    rd(OFS_P7_DIR, 1'b0, 8'h00, "dir7");
    rd(4'h3, 1'b0, 8'h00, "unmapped");
    wr(OFS_P6_PULL, 8'hff);
    wr(OFS_P7_PULL, 8'hff);
    rd(OFS_P7_PULL, 1'b0, 8'h07, "pull7");
    wt(2);
    chk(port6PullOn, 8'hff, "pullon6");
    chk({5'h00, port7PullOn}, 8'h07, "pullon7");
    rd(OFS_P6_DATA, 1'b0, 8'hff, "pin6");
    $display("reset test done");
    for (int i = 0; i < 7; i++) begin
      @(posedge clk);
      pen <= 7'h01 << i;
      wt(3);
      chk({1'b0, port7PadOeN[0], port6PadOeN[6:5], port6PadOeN[3:0]},
        {1'b0, ~pen}, "peripheral oe");
      rd(OFS_P6_DATA, 1'b0, {1'b1, ~pen[5:4], 1'b1, ~pen[3:0]}, "per6");
      rd(OFS_P7_DATA, 1'b0, {5'h00, 2'h3, ~pen[6]}, "per7");
    end
    @(posedge clk);
    pen <= 7'h00;
    ext6En <= 8'hb0;
    $display("peripheral test done");
    wr(OFS_P6_DATA, 8'h5a);
    wt(2);
    chk(port6PadOeN, 8'hff, "input held");
    wr(OFS_P6_DIR, 8'h0f);
    wt(2);
    chk(port6PadOeN, 8'hf0, "oe6 out");
    chk(port6PadOut & 8'h0f, 8'h0a, "drive6");
    chk(port6PullOn, 8'hfa, "pull low");
    rd(OFS_P6_DATA, 1'b0, 8'hfa, "read6");
    rd(OFS_P6_DATA, 1'b1, 8'h5a, "rmw6");
    @(posedge clk);
    pout <= 7'h01;
    pen <= 7'h01;
    wt(3);
    rd(OFS_P6_DATA, 1'b0, 8'hfb, "owned read");
    @(posedge clk);
    pen <= 7'h00;
    $display("direction test done");
    wr(OFS_P7_DIR, 8'hff);
    wr(OFS_P7_DATA, 8'hfd);
    rd(OFS_P7_DIR, 1'b0, 8'h07, "dir7 narrow");
    rd(OFS_P7_DATA, 1'b0, 8'h05, "read7");
    chk({5'h00, port7PadOut}, 8'h05, "drive7");
    chk({5'h00, port7PullOn}, 8'h05, "pull low7");
    chk({7'h00, reloadTimer0In}, 8'h00, "timer in");
    $display("narrow port test done");
    @(posedge clk);
    standbyEnter <= 1'b1;
    wt(3);
    chk(port6PadOeN, 8'hf0, "standby hold");
    wr(OFS_WAKE, 8'h01);
    wr(OFS_STBY, 8'h01);
    wt(3);
    chk(port6PadOeN, 8'hff, "float oe");
    chk(port6PullOn, 8'h00, "float pull");
    chk({5'h00, serialDataIn, serialClockIn, compTimer1ClockIn}, 8'h02,
      "kept inputs");
    wr(OFS_WAKE, 8'h03);
    wt(2);
    chk({5'h00, serialDataIn, serialClockIn, compTimer1ClockIn}, 8'h06,
      "both kept");
    @(posedge clk);
    standbyEnter <= 1'b0;
    wr(OFS_STBY, 8'h00);
    wt(3);
    chk(port6PadOeN, 8'hf0, "wake oe");
    $display("standby test done");
    @(posedge clk);
    rst <= 1'b1;
    wt(3);
    chk(port6PadOeN, 8'hff, "oe6 rereset");
    @(posedge clk);
    rst <= 1'b0;
    rd(OFS_P6_DIR, 1'b0, 8'h00, "dir6 rereset");
    $display("second reset test done");
    closeOut();
  end
endmodule
`default_nettype wire
